// ==== rtl/tpc_pkg.sv ====
// Shared constants and carriers for the timing input pin port control.
// Assumes a single 10 MHz core clock and a plain strobe register port.
package tpc_pkg;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [11:0] OFF_PORT_ON       = 12'h000;
  localparam logic [11:0] OFF_PORT_RELEASE  = 12'h004;
  localparam logic [11:0] OFF_PORT_STATE    = 12'h008;
  localparam logic [11:0] OFF_DRV_ON        = 12'h010;
  localparam logic [11:0] OFF_DRV_OFF       = 12'h014;
  localparam logic [11:0] OFF_DRV_STATE     = 12'h018;
  localparam logic [11:0] OFF_LVL_SET       = 12'h030;
  localparam logic [11:0] OFF_LVL_CLEAR     = 12'h034;
  localparam logic [11:0] OFF_LVL_STATE     = 12'h038;
  localparam logic [11:0] OFF_PIN_STATE     = 12'h03c;
  localparam logic [11:0] OFF_OD_ON         = 12'h040;
  localparam logic [11:0] OFF_OD_OFF        = 12'h044;
  localparam logic [11:0] OFF_OD_STATE      = 12'h048;
  localparam logic [11:0] OFF_CLK_ON        = 12'h050;
  localparam logic [11:0] OFF_CLK_OFF       = 12'h054;
  localparam logic [11:0] OFF_CLK_STATE     = 12'h058;

  // ==========================================================================
  // Field positions
  localparam int INPUT_LINE_BIT       = 16;
  localparam int PORT_LOGIC_CLOCK_BIT = 0;
  localparam int MEASURE_CLOCK_BIT    = 1;
  localparam int NUM_CLOCKS           = 2;

  // ==========================================================================
  // Reset values
  localparam logic             RST_PORT_SEL = 1'b0;
  localparam logic             RST_DRV_EN   = 1'b0;
  localparam logic             RST_OUT_LVL  = 1'b0;
  localparam logic             RST_OPEN_DR  = 1'b0;
  localparam logic [1:0]       RST_CLOCKS   = 2'h0;
  localparam logic [31:0]      RST_RD_DATA  = 32'h0000_0000;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic        wrStb;
    logic        rdStb;
    logic [11:0] addr;
    logic [31:0] wrData;
  } tpc_bus_req_t;

  typedef struct packed {
    logic pinOut;
    logic pinOe;
  } tpc_pin_drv_t;

endpackage

// ==== rtl/tpc_port_ctrl.sv ====
// Port-control and clock-gating front end of a one-pin timing input block.
// Assumes a strobe register port on core_clk and an asynchronous external pin.
`timescale 1ns/1ps

module tpc_port_ctrl (
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  input  wire logic                 softRst,
  input  wire tpc_pkg::tpc_bus_req_t busReq,
  output      logic [31:0]          rdData,
  input  wire logic                 pinIn,
  output      logic                 pinOut,
  output      logic                 pinOe,
  output      logic                 measPinLevel,
  output      logic                 measClkEn,
  output      logic                 portClkEn
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic        portSel;
    logic        drvEn;
    logic        outLvl;
    logic        openDrain;
    logic [1:0]  clocks;
    logic [2:0]  pinSync;
    logic        pinLevel;
    logic        pinOut;
    logic        pinOe;
    logic [31:0] rdData;
  } tpc_state_t;

  tpc_state_t st_r;
  tpc_state_t st_nxt;

  // ==========================================================================
  // Decode helpers
  // Only the documented line bit of a matching write counts
  function automatic logic lineHit(input tpc_pkg::tpc_bus_req_t req,
                                   input logic [11:0]         off);
    lineHit = req.wrStb && (req.addr == off) && req.wrData[tpc_pkg::INPUT_LINE_BIT];
  endfunction

  function automatic logic wrHit(input tpc_pkg::tpc_bus_req_t req,
                                 input logic [11:0]         off);
    wrHit = req.wrStb && (req.addr == off);
  endfunction

  function automatic logic [31:0] lineWord(input logic v);
    lineWord = 32'h0000_0000;
    lineWord[tpc_pkg::INPUT_LINE_BIT] = v;
  endfunction

  // ==========================================================================
  // Next state
  always_comb begin
    logic [31:0] rd;
    rd     = 32'h0000_0000;
    st_nxt = st_r;

    if (lineHit(busReq, tpc_pkg::OFF_PORT_ON)) begin
      st_nxt.portSel = 1'b1;
    end
    if (lineHit(busReq, tpc_pkg::OFF_PORT_RELEASE)) begin
      st_nxt.portSel = 1'b0;
    end
    if (lineHit(busReq, tpc_pkg::OFF_DRV_ON)) begin
      st_nxt.drvEn = 1'b1;
    end
    if (lineHit(busReq, tpc_pkg::OFF_DRV_OFF)) begin
      st_nxt.drvEn = 1'b0;
    end
    if (lineHit(busReq, tpc_pkg::OFF_LVL_SET)) begin
      st_nxt.outLvl = 1'b1;
    end
    if (lineHit(busReq, tpc_pkg::OFF_LVL_CLEAR)) begin
      st_nxt.outLvl = 1'b0;
    end
    if (lineHit(busReq, tpc_pkg::OFF_OD_ON)) begin
      st_nxt.openDrain = 1'b1;
    end
    if (lineHit(busReq, tpc_pkg::OFF_OD_OFF)) begin
      st_nxt.openDrain = 1'b0;
    end

    for (int i = 0; i < tpc_pkg::NUM_CLOCKS; i++) begin
      if (wrHit(busReq, tpc_pkg::OFF_CLK_ON) && busReq.wrData[i]) begin
        st_nxt.clocks[i] = 1'b1;
      end
      if (wrHit(busReq, tpc_pkg::OFF_CLK_OFF) && busReq.wrData[i]) begin
        st_nxt.clocks[i] = 1'b0;
      end
    end

    // Software reset returns port setup to defaults but not clock gating
    if (softRst) begin
      st_nxt.portSel   = tpc_pkg::RST_PORT_SEL;
      st_nxt.drvEn     = tpc_pkg::RST_DRV_EN;
      st_nxt.outLvl    = tpc_pkg::RST_OUT_LVL;
      st_nxt.openDrain = tpc_pkg::RST_OPEN_DR;
    end

    // three-stage pin sampling, accept when stages two and three agree
    st_nxt.pinSync = {st_r.pinSync[1:0], pinIn};
    if (st_r.pinSync[1] == st_r.pinSync[2]) begin
      st_nxt.pinLevel = st_r.pinSync[2];
    end

    // Open drain only pulls low; a high level releases the line
    st_nxt.pinOe  = st_nxt.portSel & st_nxt.drvEn & ~(st_nxt.openDrain & st_nxt.outLvl);
    st_nxt.pinOut = st_nxt.outLvl & ~st_nxt.openDrain;

    // Read mux; write-only and unmapped addresses return zero
    if (busReq.rdStb) begin
      case (busReq.addr)
        tpc_pkg::OFF_PORT_STATE: rd = lineWord(st_r.portSel);
        tpc_pkg::OFF_DRV_STATE:  rd = lineWord(st_r.drvEn);
        tpc_pkg::OFF_LVL_STATE:  rd = lineWord(st_r.outLvl);
        tpc_pkg::OFF_PIN_STATE:  rd = lineWord(st_r.pinLevel);
        tpc_pkg::OFF_OD_STATE:   rd = lineWord(st_r.openDrain);
        tpc_pkg::OFF_CLK_STATE:  rd = {30'h0000_0000, st_r.clocks};
        default:                 rd = 32'h0000_0000;
      endcase
    end
    st_nxt.rdData = rd;
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_r.portSel   <= tpc_pkg::RST_PORT_SEL;
      st_r.drvEn     <= tpc_pkg::RST_DRV_EN;
      st_r.outLvl    <= tpc_pkg::RST_OUT_LVL;
      st_r.openDrain <= tpc_pkg::RST_OPEN_DR;
      // clocks cleared by hardware reset only
      st_r.clocks    <= tpc_pkg::RST_CLOCKS;
      st_r.pinSync   <= 3'h0;
      st_r.pinLevel  <= 1'b0;
      st_r.pinOut    <= 1'b0;
      st_r.pinOe     <= 1'b0;
      st_r.rdData    <= tpc_pkg::RST_RD_DATA;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign rdData       = st_r.rdData;
  assign pinOut       = st_r.pinOut;
  assign pinOe        = st_r.pinOe;
  assign measPinLevel = st_r.pinLevel;
  assign measClkEn    = st_r.clocks[tpc_pkg::MEASURE_CLOCK_BIT];
  assign portClkEn    = st_r.clocks[tpc_pkg::PORT_LOGIC_CLOCK_BIT];

  // ==========================================================================
  // Assertions
  sequence s_rd(logic [11:0] off);
    busReq.rdStb && (busReq.addr == off);
  endsequence

  sequence s_wr(logic [11:0] off);
    busReq.wrStb && (busReq.addr == off) && busReq.wrData[tpc_pkg::INPUT_LINE_BIT];
  endsequence

  // Line write that no same-cycle software reset overrides
  sequence s_wr_live(logic [11:0] off);
    busReq.wrStb && (busReq.addr == off) && !softRst &&
      busReq.wrData[tpc_pkg::INPUT_LINE_BIT];
  endsequence

  property p_port_state_read;
    @(posedge core_clk) disable iff (!rstn)
      s_rd(tpc_pkg::OFF_PORT_STATE) |=>
        rdData == {15'h0000, $past(st_r.portSel), 16'h0000};
  endproperty
  a_port_state_read: assert property (p_port_state_read)
    else $error("port select status readback wrong");

  property p_release;
    @(posedge core_clk) disable iff (!rstn)
      s_wr(tpc_pkg::OFF_PORT_RELEASE) ##1 s_rd(tpc_pkg::OFF_PORT_STATE) |=>
        rdData[tpc_pkg::INPUT_LINE_BIT] == 1'b0;
  endproperty
  a_release: assert property (p_release)
    else $error("release did not give pin to measurement");

  property p_port_on;
    @(posedge core_clk) disable iff (!rstn)
      s_wr_live(tpc_pkg::OFF_PORT_ON) |=> st_r.portSel;
  endproperty
  a_port_on: assert property (p_port_on)
    else $error("port-on did not select GPIO");

  property p_drv;
    @(posedge core_clk) disable iff (!rstn)
      (s_wr_live(tpc_pkg::OFF_DRV_ON) |=> st_r.drvEn) and
      (s_wr(tpc_pkg::OFF_DRV_OFF) |=> !st_r.drvEn && !pinOe);
  endproperty
  a_drv: assert property (p_drv)
    else $error("driver enable set or clear failed");

  property p_drv_state;
    @(posedge core_clk) disable iff (!rstn)
      s_rd(tpc_pkg::OFF_DRV_STATE) |=>
        rdData[tpc_pkg::INPUT_LINE_BIT] == $past(st_r.drvEn);
  endproperty
  a_drv_state: assert property (p_drv_state)
    else $error("driver status readback wrong");

  property p_level;
    @(posedge core_clk) disable iff (!rstn)
      s_wr_live(tpc_pkg::OFF_LVL_SET) ##1 s_rd(tpc_pkg::OFF_LVL_STATE) |=>
        rdData[tpc_pkg::INPUT_LINE_BIT];
  endproperty
  a_level: assert property (p_level)
    else $error("level set not visible in status");

  property p_pin_drive;
    @(posedge core_clk) disable iff (!rstn)
      pinOe |-> (pinOut == st_r.outLvl) && st_r.portSel && st_r.drvEn;
  endproperty
  a_pin_drive: assert property (p_pin_drive)
    else $error("driven pin level differs from level status");

  property p_pin_level;
    @(posedge core_clk) disable iff (!rstn)
      pinIn[*6] |-> measPinLevel;
  endproperty
  a_pin_level: assert property (p_pin_level)
    else $error("pin level not followed within sync delay");

  property p_open_drain;
    @(posedge core_clk) disable iff (!rstn)
      st_r.openDrain && pinOe |-> !pinOut;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open drain drove a high level");

  property p_od_state;
    @(posedge core_clk) disable iff (!rstn)
      s_rd(tpc_pkg::OFF_OD_STATE) |=>
        rdData[tpc_pkg::INPUT_LINE_BIT] == $past(st_r.openDrain);
  endproperty
  a_od_state: assert property (p_od_state)
    else $error("open drain status readback wrong");

  property p_clk_on;
    @(posedge core_clk) disable iff (!rstn)
      busReq.wrStb && busReq.addr == tpc_pkg::OFF_CLK_ON && busReq.wrData[1] |=> measClkEn;
  endproperty
  a_clk_on: assert property (p_clk_on)
    else $error("measurement clock not enabled");

  property p_clk_off;
    @(posedge core_clk) disable iff (!rstn)
      busReq.wrStb && busReq.addr == tpc_pkg::OFF_CLK_OFF && busReq.wrData[0] |=> !portClkEn;
  endproperty
  a_clk_off: assert property (p_clk_off)
    else $error("port clock not stopped");

  property p_clk_state;
    @(posedge core_clk) disable iff (!rstn)
      s_rd(tpc_pkg::OFF_CLK_STATE) |=>
        rdData == {30'h0000_0000, $past(measClkEn), $past(portClkEn)};
  endproperty
  a_clk_state: assert property (p_clk_state)
    else $error("clock status readback wrong");

  property p_soft_keep;
    @(posedge core_clk) disable iff (!rstn)
      softRst && !wrHit(busReq, tpc_pkg::OFF_CLK_ON) && !wrHit(busReq, tpc_pkg::OFF_CLK_OFF)
        |=> $stable(st_r.clocks) && !st_r.portSel;
  endproperty
  a_soft_keep: assert property (p_soft_keep)
    else $error("software reset touched clock state");

  property p_zero_write;
    @(posedge core_clk) disable iff (!rstn)
      busReq.wrStb && !busReq.wrData[tpc_pkg::INPUT_LINE_BIT] && !softRst |=>
        $stable(st_r.portSel) && $stable(st_r.drvEn) && $stable(st_r.outLvl);
  endproperty
  a_zero_write: assert property (p_zero_write)
    else $error("zero write changed line state");

  property p_release_oe;
    @(posedge core_clk) disable iff (!rstn)
      s_wr_live(tpc_pkg::OFF_PORT_RELEASE) |=> !st_r.portSel && !pinOe;
  endproperty
  a_release_oe: assert property (p_release_oe)
    else $error("release left the port driver on");

  property p_level_clear;
    @(posedge core_clk) disable iff (!rstn)
      s_wr_live(tpc_pkg::OFF_LVL_CLEAR) ##1 s_rd(tpc_pkg::OFF_LVL_STATE) |=>
        !rdData[tpc_pkg::INPUT_LINE_BIT];
  endproperty
  a_level_clear: assert property (p_level_clear)
    else $error("level clear not visible in status");

  property p_od_set;
    @(posedge core_clk) disable iff (!rstn)
      (s_wr_live(tpc_pkg::OFF_OD_ON) |=> st_r.openDrain) and
      (s_wr(tpc_pkg::OFF_OD_OFF) |=> !st_r.openDrain);
  endproperty
  a_od_set: assert property (p_od_set)
    else $error("open drain set or clear failed");

  property p_clk_port_on;
    @(posedge core_clk) disable iff (!rstn)
      wrHit(busReq, tpc_pkg::OFF_CLK_ON) && busReq.wrData[tpc_pkg::PORT_LOGIC_CLOCK_BIT] |=>
        portClkEn;
  endproperty
  a_clk_port_on: assert property (p_clk_port_on)
    else $error("port clock not enabled");

  property p_clk_meas_off;
    @(posedge core_clk) disable iff (!rstn)
      wrHit(busReq, tpc_pkg::OFF_CLK_OFF) && busReq.wrData[tpc_pkg::MEASURE_CLOCK_BIT] |=>
        !measClkEn;
  endproperty
  a_clk_meas_off: assert property (p_clk_meas_off)
    else $error("measurement clock not stopped");

  property p_clk_zero;
    @(posedge core_clk) disable iff (!rstn)
      busReq.wrStb && (busReq.wrData[1:0] == 2'h0) |=> $stable(st_r.clocks);
  endproperty
  a_clk_zero: assert property (p_clk_zero)
    else $error("zero clock write changed clock state");

  // Disagreeing stages must hold the level; this is the glitch filter
  property p_pin_hold;
    @(posedge core_clk) disable iff (!rstn)
      (st_r.pinSync[1] != st_r.pinSync[2]) |=> $stable(measPinLevel);
  endproperty
  a_pin_hold: assert property (p_pin_hold)
    else $error("pin level moved before sync stages agreed");

  property p_soft_clear;
    @(posedge core_clk) disable iff (!rstn)
      softRst |=> !st_r.portSel && !st_r.drvEn && !st_r.outLvl && !st_r.openDrain && !pinOe;
  endproperty
  a_soft_clear: assert property (p_soft_clear)
    else $error("software reset left port setup in place");

  property p_pin_level_low;
    @(posedge core_clk) disable iff (!rstn)
      (!pinIn)[*6] |-> !measPinLevel;
  endproperty
  a_pin_level_low: assert property (p_pin_level_low)
    else $error("low pin level not followed within sync delay");

endmodule // tpc_port_ctrl

// ==== test/timing_input_pin_port_control_tb.sv ====
// Self-checking bench for the pin port control block.
// Assumes the strobe register port and a 10 MHz core clock.
`timescale 1ns/1ps

module timing_input_pin_port_control_tb;
  logic                  core_clk;
  logic                  rstn;
  logic                  softRst;
  tpc_pkg::tpc_bus_req_t busReq;
  logic [31:0]           rdData;
  logic                  pinIn, pinOut, pinOe, measPinLevel, measClkEn, portClkEn;
  logic                  extEn, extLvl, rdSeen, ps, drv, lv, od;
  logic [1:0]            ck;
  logic [31:0]           rnd;
  logic [31:0]           expQ[$];
  int                    miscompares, testsRun, cycles;
  localparam logic [11:0] WOFF [12] = '{12'h000, 12'h010, 12'h030, 12'h040, 12'h050,
    12'h044, 12'h014, 12'h034, 12'h004, 12'h054, 12'h008, 12'h0ff};
  localparam logic [11:0] ROFF [8] = '{12'h008, 12'h018, 12'h038, 12'h03c, 12'h048,
    12'h058, 12'h000, 12'h0ff};

  tpc_port_ctrl uut (.core_clk(core_clk), .rstn(rstn), .softRst(softRst), .busReq(busReq),
    .rdData(rdData), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .measPinLevel(measPinLevel), .measClkEn(measClkEn), .portClkEn(portClkEn));
  tpc_pin_model pin (.pinOut(pinOut), .pinOe(pinOe), .extEn(extEn), .extLvl(extLvl),
    .pinIn(pinIn));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic pinLvl();
    logic oe;
    oe = ps & drv & ~(od & lv);
    return oe ? (lv & ~od) : (extEn ? extLvl : 1'b1);
  endfunction

  function automatic logic [31:0] expRd(input logic [11:0] a);
    case (a)
      12'h008: return {15'h0000, ps, 16'h0000};
      12'h018: return {15'h0000, drv, 16'h0000};
      12'h038: return {15'h0000, lv, 16'h0000};
      12'h03c: return {15'h0000, pinLvl(), 16'h0000};
      12'h048: return {15'h0000, od, 16'h0000};
      12'h058: return {30'h00000000, ck};
      default: return 32'h00000000;
    endcase
  endfunction

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    testsRun++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrReq(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    busReq <= '{1'b1, 1'b0, a, d};
    case (a)
      12'h000: if (d[16]) ps = 1'b1;
      12'h004: if (d[16]) ps = 1'b0;
      12'h010: if (d[16]) drv = 1'b1;
      12'h014: if (d[16]) drv = 1'b0;
      12'h030: if (d[16]) lv = 1'b1;
      12'h034: if (d[16]) lv = 1'b0;
      12'h040: if (d[16]) od = 1'b1;
      12'h044: if (d[16]) od = 1'b0;
      12'h050: ck = ck | d[1:0];
      12'h054: ck = ck & ~d[1:0];
      default: ;
    endcase
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    wrReq(a, d);
    @(posedge core_clk);
    busReq.wrStb <= 1'b0;
  endtask

  task automatic rdReq(input logic [11:0] a);
    @(posedge core_clk);
    expQ.push_back(expRd(a));
    busReq <= '{1'b0, 1'b1, a, rnd};
  endtask

  task automatic rd(input logic [11:0] a);
    rdReq(a);
    @(posedge core_clk);
    busReq.rdStb <= 1'b0;
  endtask

  // Back-to-back strobes: the read sees the write at once
  task automatic wrRd(input logic [11:0] a, input logic [31:0] d, input logic [11:0] ra);
    wrReq(a, d);
    rdReq(ra);
    @(posedge core_clk);
    busReq.rdStb <= 1'b0;
  endtask

  // Pin filter needs four edges, so settle before looking
  task automatic chkAll();
    repeat (6) @(posedge core_clk);
    #10;
    cmp("pinOe", {31'h0, ps & drv & ~(od & lv)}, {31'h0, pinOe});
    cmp("pinOut", {31'h0, lv & ~od}, {31'h0, pinOut});
    cmp("measPinLevel", {31'h0, pinLvl()}, {31'h0, measPinLevel});
    cmp("clocks", {30'h0, ck}, {30'h0, measClkEn, portClkEn});
    foreach (ROFF[i]) rd(ROFF[i]);
    repeat (2) @(posedge core_clk);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================================================
  // Result watcher and hang guard
  always @(posedge core_clk) rdSeen <= busReq.rdStb;

  always @(negedge core_clk) begin
    if (rdSeen === 1'b1 && expQ.size() > 0)
      cmp("rdData", expQ.pop_front(), rdData);
    else if (rstn === 1'b1)
      cmp("rdIdle", 32'h00000000, rdData);
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    rstn = 1'b0;
    softRst = 1'b0;
    busReq = '0;
    extEn = 1'b0;
    extLvl = 1'b0;
    rdSeen = 1'b0;
    {ps, drv, lv, od, ck} = '0;
    rnd = 32'h0001_075e;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    chkAll();
    $display("test reset done");
    foreach (WOFF[i]) begin
      wr(WOFF[i], 32'h00010003);
      chkAll();
    end
    $display("test directed done");
    for (int i = 0; i < 60; i++) begin
      rnd = lfsr(rnd);
      extEn <= rnd[20];
      extLvl <= rnd[21];
      wr(WOFF[rnd[7:0] % 8'h0c], rnd);
      chkAll();
    end
    $display("test random done");
    wrRd(12'h000, 32'h00010000, 12'h008);
    wrRd(12'h004, 32'h00010000, 12'h008);
    wrRd(12'h030, 32'h00010000, 12'h038);
    wrRd(12'h034, 32'h00010000, 12'h038);
    wrRd(12'h040, 32'h00010000, 12'h048);
    wrRd(12'h054, 32'h00000001, 12'h058);
    chkAll();
    $display("test back to back done");
    extEn <= 1'b1;
    extLvl <= 1'b0;
    for (int i = 0; i < 5; i++) wr(WOFF[i], 32'hffffffff);
    @(posedge core_clk);
    softRst <= 1'b1;
    @(posedge core_clk);
    softRst <= 1'b0;
    {ps, drv, lv, od} = '0;
    chkAll();
    $display("test soft reset done");
    rstn <= 1'b0;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    {ps, drv, lv, od, ck} = '0;
    chkAll();
    $display("test hard reset done");
    report_and_stop();
  end
endmodule // timing_input_pin_port_control_tb

// ==== test/tpc_pin_model.sv ====
// External source model on the single timing input pin.
// Assumes a pull-up on the pin and a bench that sets the source level.
`timescale 1ns/1ps

module tpc_pin_model (
  input  wire logic pinOut,
  input  wire logic pinOe,
  input  wire logic extEn,
  input  wire logic extLvl,
  output      logic pinIn
);
  // Pull-up holds the line high when nobody drives it
  assign pinIn = pinOe ? pinOut : (extEn ? extLvl : 1'b1);
endmodule // tpc_pin_model
